// ==== logic/mon_pkg.sv ====
// Constants, types and encodings shared by the monitor serial slave port.
package mon_pkg;

	// Clock rate and the timing figures derived from it.
	localparam int CLK_HZ    = 20_000_000;
	localparam int PULSE_US  = 16;
	localparam int PULSE_CYC = (PULSE_US * (CLK_HZ / 1_000) + 999) / 1_000;
	localparam int STUCK_MS  = 33;
	localparam int STUCK_CYC = STUCK_MS * (CLK_HZ / 1_000);

	// Register pointer values and offsets.
	localparam logic [7:0] PTR_RST    = 8'h00;
	localparam logic [7:0] PTR_LAST   = 8'h97;
	localparam logic [7:0] STAT_ADDR  = 8'h96;
	localparam logic [7:0] ID_HI_ADDR = 8'hE7;
	localparam logic [7:0] ID_LO_ADDR = 8'hE8;
	// Identifier contents; the values are arbitrary.
	localparam logic [7:0] ID_HI_VAL  = 8'h5A;
	localparam logic [7:0] ID_LO_VAL  = 8'hA5;
	localparam logic [7:0] STAT_RST   = 8'h00;

	// Slave address pieces.
	localparam logic [2:0] ADDR_PREFIX = 3'h6;
	localparam logic [6:0] MASS_ADDR   = 7'h66;
	localparam logic [6:0] ARA_ADDR    = 7'h0C;

	// Three-state strap codes as sensed by the pad.
	localparam logic [1:0] STRAP_LOW  = 2'h0;
	localparam logic [1:0] STRAP_OPEN = 2'h1;
	localparam logic [1:0] STRAP_HIGH = 2'h2;

	// Serial engine states.
	typedef enum logic [2:0] {
		ST_IDLE     = 3'h0,
		ST_ADDR     = 3'h1,
		ST_ADDR_ACK = 3'h2,
		ST_RX       = 3'h3,
		ST_RX_ACK   = 3'h4,
		ST_TX       = 3'h5,
		ST_TX_ACK   = 3'h6
	} mon_state_t;

	// New-data strobe signalling modes.
	typedef enum logic [1:0] {
		DR_OFF   = 2'h0,
		DR_PULSE = 2'h1,
		DR_LATCH = 2'h2
	} mon_dr_mode_t;

endpackage

// ==== logic/mon_dr_if.sv ====
// Interface between the serial port and the new-data strobe unit.
`timescale 1ns/1ps
interface mon_dr_if;
	logic                  new_data;  // Any fresh result this cycle.
	mon_pkg::mon_dr_mode_t mode;      // Strobe signalling mode.
	logic                  clear;     // Status register has been read.
	logic                  strobe_n;  // Strobe pin level.
	logic                  strobe_oe; // Strobe pull-down enable.

	modport ctrl (output new_data, output mode, output clear,
		input strobe_n, input strobe_oe);
	modport strobe (input new_data, input mode, input clear,
		output strobe_n, output strobe_oe);
endinterface

// ==== logic/mon_sync.sv ====
// Two-flop synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ps
module mon_sync #(
	parameter int W = 1
) (
	input  wire logic         sys_clk, // System clock.
	input  wire logic         nrst,    // Asynchronous reset, active low.
	input  wire logic [W-1:0] d,       // Asynchronous inputs.
	output logic      [W-1:0] q        // Synchronised outputs.
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} mon_sync_st_t;

	mon_sync_st_t r;
	mon_sync_st_t next_r;

	// The first stage feeds only the second stage.
	always_comb begin
		next_r.s1 = d;
		next_r.s2 = r.s1;
	end

	// Register the stages; reset to the idle high bus level.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			r <= '1;
		end else begin
			r <= next_r;
		end
	end

	assign q = r.s2;
endmodule

// ==== logic/mon_dr_strobe.sv ====
// New-data strobe generator for the third auxiliary pin.
`timescale 1ns/1ps
module mon_dr_strobe (
	input wire logic sys_clk, // System clock.
	input wire logic nrst,    // Asynchronous reset, active low.
	mon_dr_if.strobe dr       // Mode, events and strobe outputs.
);
	localparam int PW = mon_pkg::PULSE_CYC;

	typedef struct packed {
		logic       drv_n;
		logic       oe;
		logic [8:0] cnt;
	} mon_dr_st_t;

	mon_dr_st_t r;
	mon_dr_st_t next_r;

	// Pulse or latch the strobe low on new data.
	always_comb begin
		next_r = r;
		unique case (dr.mode)
			mon_pkg::DR_PULSE: begin
				if (r.cnt != 9'h000) begin
					next_r.cnt = r.cnt - 9'h001;
					if (r.cnt == 9'h001) begin
						next_r.drv_n = 1'b1;
					end
				end else if (dr.new_data) begin
					next_r.drv_n = 1'b0;
					next_r.cnt = 9'(PW);
				end
			end
			mon_pkg::DR_LATCH: begin
				next_r.cnt = 9'h000;
				if (dr.new_data) begin
					next_r.drv_n = 1'b0;
				end else if (dr.clear) begin
					next_r.drv_n = 1'b1;
				end
			end
			default: begin
				next_r.drv_n = 1'b1;
				next_r.cnt = 9'h000;
			end
		endcase
		next_r.oe = ~next_r.drv_n;
	end

	// Register the strobe state.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			r <= '{drv_n: 1'b1, oe: 1'b0, cnt: 9'h000};
		end else begin
			r <= next_r;
		end
	end

	assign dr.strobe_n = r.drv_n;
	assign dr.strobe_oe = r.oe;

	////////////////////////////////////////////////////////////////////////
	// Checks.
	chk_pulse_low_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
		($fell(r.drv_n) && dr.mode == mon_pkg::DR_PULSE) |-> !r.drv_n[*8])
		else $error("strobe pulse ended early");
	chk_pulse_end_time: assert property (@(posedge sys_clk) disable iff (!nrst)
		($fell(r.drv_n) && dr.mode == mon_pkg::DR_PULSE)
		##1 (dr.mode == mon_pkg::DR_PULSE)[*8]
		##12 (dr.mode == mon_pkg::DR_PULSE)
		|-> ##299 !r.drv_n ##1 r.drv_n)
		else $error("strobe pulse has wrong length");
	chk_latch_release: assert property (@(posedge sys_clk) disable iff (!nrst)
		(dr.mode == mon_pkg::DR_LATCH && !r.drv_n && !dr.new_data
		&& !dr.clear) |=> !r.drv_n)
		else $error("latched strobe released without read");
	cov_pulse: cover property (@(posedge sys_clk) disable iff (!nrst)
		$fell(r.drv_n) && dr.mode == mon_pkg::DR_PULSE);
endmodule

// ==== logic/mon_i2c_slave.sv ====
// Serial slave port of the power monitor with pointer, status and strobe.
`timescale 1ns/1ps
module mon_i2c_slave #(
	parameter logic [19:0] STUCK_CYC = 20'(mon_pkg::STUCK_CYC)
) (
	input  wire logic       sys_clk,            // System clock.
	input  wire logic       nrst,               // Async reset, active low.
	input  wire logic       scl_in,             // Serial clock pin.
	input  wire logic       serial_data_in,     // Serial data input pin.
	output logic            serial_data_out,    // Data output pin level.
	output logic            serial_data_out_oe, // Data pull-down enable.
	input  wire logic [1:0] addr_strap_zero,    // First strap pad code.
	input  wire logic [1:0] addr_strap_one,     // Second strap pad code.
	input  wire logic       shutdown,           // Low-power shutdown.
	input  wire logic       alert_pending,      // Alert output asserted.
	output logic            alert_ack,          // Alert address answered.
	input  wire logic [7:0] adc_new_evt,        // Fresh result pulses.
	input  wire logic [1:0] dr_mode,            // Strobe mode select.
	output logic            aux_pin_three,      // Strobe pin level.
	output logic            aux_pin_three_oe,   // Strobe pull-down enable.
	output logic [7:0]      reg_addr,           // Register pointer.
	output logic [7:0]      reg_wdata,          // Register write data.
	output logic            reg_we,             // Register write pulse.
	output logic            reg_re,             // Register read pulse.
	input  wire logic [7:0] reg_rdata,          // Register read data.
	output logic [7:0]      adc_status          // Status register value.
);
	typedef struct packed {
		mon_pkg::mon_state_t st;
		logic [3:0]          bitc;
		logic [7:0]          sh;
		logic [7:0]          ptr;
		logic                cmd;
		logic                dat;
		logic                rw;
		logic                ara;
		logic                ack;
		logic                oe;
		logic                sdo;
		logic                scl_d;
		logic                sda_d;
		logic [19:0]         stuck;
		logic [7:0]          status;
		logic                we;
		logic                re;
		logic [7:0]          wdata;
		logic                stat_clr;
		logic                alert_ack;
		logic [1:0]          s0;
		logic [1:0]          s1;
	} mon_top_st_t;

	mon_top_st_t r;
	mon_top_st_t next_r;

	logic [5:0] sync_q;
	logic       scl_s;
	logic       sda_s;
	logic [1:0] s0_s;
	logic [1:0] s1_s;

	////////////////////////////////////////////////////////////////////////
	// Input synchronisation and strobe unit.

	// Every pin input passes two flops before use.
	mon_sync #(
		.W(6)
	) u_sync (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.d       ({scl_in, serial_data_in, addr_strap_zero,
			addr_strap_one}),
		.q       (sync_q)
	);

	assign scl_s = sync_q[5];
	assign sda_s = sync_q[4];
	assign s0_s = sync_q[3:2];
	assign s1_s = sync_q[1:0];

	mon_dr_if dr ();

	// Strobe unit sees new data, the mode and the status-read event.
	assign dr.new_data = |adc_new_evt;
	assign dr.mode = mon_pkg::mon_dr_mode_t'(dr_mode);
	assign dr.clear = r.stat_clr;

	mon_dr_strobe u_strobe (
		.sys_clk (sys_clk),
		.nrst    (nrst),
		.dr      (dr)
	);

	////////////////////////////////////////////////////////////////////////
	// Bus events and address decode.

	logic       rise;
	logic       fall;
	logic       start_det;
	logic       stop_det;
	logic       stuck_hit;
	logic [1:0] v0;
	logic [1:0] v1;
	logic [3:0] low4;
	logic [6:0] own_addr;
	logic       is_own;
	logic       is_mass;
	logic       is_ara;
	logic       addr_ok;
	logic       addr_done;
	logic       ptr_inc;
	logic [7:0] ptr_next;
	logic [7:0] rd;

	// Edges of the clock line and START or STOP while it is high.
	assign rise = scl_s && !r.scl_d;
	assign fall = !scl_s && r.scl_d;
	assign start_det = scl_s && r.scl_d && r.sda_d && !sda_s;
	assign stop_det = scl_s && r.scl_d && !r.sda_d && sda_s;
	assign stuck_hit = (r.stuck >= STUCK_CYC);

	// Map each strap to 0..2 and form one of nine low address nibbles.
	assign v0 = (r.s0 == mon_pkg::STRAP_HIGH) ? 2'h2 :
		((r.s0 == mon_pkg::STRAP_LOW) ? 2'h0 : 2'h1);
	assign v1 = (r.s1 == mon_pkg::STRAP_HIGH) ? 2'h2 :
		((r.s1 == mon_pkg::STRAP_LOW) ? 2'h0 : 2'h1);
	assign low4 = 4'({2'h0, v0} * 4'h3 + {2'h0, v1});
	assign own_addr = {mon_pkg::ADDR_PREFIX, low4};

	// Address match on the eighth bit; the last bit is the direction.
	assign is_own = (r.sh[7:1] == own_addr);
	assign is_mass = (r.sh[7:1] == mon_pkg::MASS_ADDR) && !r.sh[0];
	assign is_ara = (r.sh[7:1] == mon_pkg::ARA_ADDR) && r.sh[0]
		&& alert_pending;
	assign addr_ok = is_own || is_mass || is_ara;
	assign addr_done = fall && !stuck_hit && !start_det && !stop_det
		&& r.st == mon_pkg::ST_ADDR && r.bitc == 4'h8;

	// Pointer advances after each data byte and wraps past the top.
	assign ptr_inc = fall && !stuck_hit && !start_det && !stop_det
		&& ((r.st == mon_pkg::ST_TX && r.bitc == 4'h8 && !r.ara)
		|| (r.st == mon_pkg::ST_RX_ACK && r.dat));
	assign ptr_next = (r.ptr == mon_pkg::PTR_LAST) ? mon_pkg::PTR_RST :
		r.ptr + 8'h01;

	// Read data source: alert reply, status, identifiers or outside.
	assign rd = r.ara ? {own_addr, 1'b1} :
		(r.ptr == mon_pkg::STAT_ADDR) ? r.status :
		(r.ptr == mon_pkg::ID_HI_ADDR) ? mon_pkg::ID_HI_VAL :
		(r.ptr == mon_pkg::ID_LO_ADDR) ? mon_pkg::ID_LO_VAL :
		reg_rdata;

	////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	// Serial engine, status register, strap store and stuck timer.
	always_comb begin
		next_r = r;
		next_r.we = 1'b0;
		next_r.re = 1'b0;
		next_r.stat_clr = 1'b0;
		next_r.alert_ack = 1'b0;
		next_r.scl_d = scl_s;
		next_r.sda_d = sda_s;
		if (!shutdown) begin
			next_r.s0 = s0_s;
			next_r.s1 = s1_s;
		end
		if (scl_s && sda_s) begin
			next_r.stuck = 20'h00000;
		end else if (!stuck_hit) begin
			next_r.stuck = r.stuck + 20'h00001;
		end
		// A new result wins over the clear in the same cycle.
		next_r.status = (r.status & ~{8{r.stat_clr}}) | adc_new_evt;
		if (stuck_hit) begin
			next_r.st = mon_pkg::ST_IDLE;
			next_r.oe = 1'b0;
			next_r.ptr = mon_pkg::PTR_RST;
		end else if (start_det) begin
			next_r.st = mon_pkg::ST_ADDR;
			next_r.bitc = 4'h0;
			next_r.oe = 1'b0;
		end else if (stop_det) begin
			next_r.st = mon_pkg::ST_IDLE;
			next_r.oe = 1'b0;
			next_r.ptr = mon_pkg::PTR_RST;
		end else if (rise) begin
			if (r.st == mon_pkg::ST_ADDR || r.st == mon_pkg::ST_RX) begin
				next_r.sh = {r.sh[6:0], sda_s};
				next_r.bitc = r.bitc + 4'h1;
			end
			if (r.st == mon_pkg::ST_TX_ACK) begin
				next_r.ack = !sda_s;
			end
		end else if (fall) begin
			unique case (r.st)
				mon_pkg::ST_ADDR: begin
					if (r.bitc == 4'h8) begin
						if (addr_ok) begin
							next_r.oe = 1'b1;
							next_r.st = mon_pkg::ST_ADDR_ACK;
							next_r.rw = r.sh[0];
							next_r.ara = is_ara;
							next_r.cmd = 1'b1;
						end else begin
							next_r.st = mon_pkg::ST_IDLE;
						end
					end
				end
				mon_pkg::ST_ADDR_ACK: begin
					if (r.rw) begin
						// First byte of a read goes out after the ack.
						next_r.st = mon_pkg::ST_TX;
						next_r.sh = {rd[6:0], 1'b0};
						next_r.oe = ~rd[7];
						next_r.bitc = 4'h1;
						next_r.re = !r.ara;
					end else begin
						next_r.oe = 1'b0;
						next_r.st = mon_pkg::ST_RX;
						next_r.bitc = 4'h0;
					end
				end
				mon_pkg::ST_RX: begin
					if (r.bitc == 4'h8) begin
						next_r.oe = 1'b1;
						next_r.st = mon_pkg::ST_RX_ACK;
						next_r.dat = !r.cmd;
						if (r.cmd) begin
							next_r.ptr = r.sh;
							next_r.cmd = 1'b0;
						end else begin
							next_r.we = 1'b1;
							next_r.wdata = r.sh;
						end
					end
				end
				mon_pkg::ST_RX_ACK: begin
					// Any number of data bytes may follow.
					next_r.oe = 1'b0;
					next_r.st = mon_pkg::ST_RX;
					next_r.bitc = 4'h0;
				end
				mon_pkg::ST_TX: begin
					if (r.bitc != 4'h8) begin
						next_r.oe = ~r.sh[7];
						next_r.sh = {r.sh[6:0], 1'b0};
						next_r.bitc = r.bitc + 4'h1;
					end else begin
						next_r.oe = 1'b0;
						next_r.st = mon_pkg::ST_TX_ACK;
						next_r.stat_clr = !r.ara
							&& r.ptr == mon_pkg::STAT_ADDR;
						next_r.alert_ack = r.ara;
					end
				end
				mon_pkg::ST_TX_ACK: begin
					if (r.ack) begin
						next_r.st = mon_pkg::ST_TX;
						next_r.sh = {rd[6:0], 1'b0};
						next_r.oe = ~rd[7];
						next_r.bitc = 4'h1;
						next_r.re = !r.ara;
					end else begin
						next_r.st = mon_pkg::ST_IDLE;
					end
				end
				default: begin
				end
			endcase
		end
		if (ptr_inc) begin
			next_r.ptr = ptr_next;
		end
		next_r.sdo = ~next_r.oe;
	end

	// Register all state.
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			r <= '{st: mon_pkg::ST_IDLE, bitc: 4'h0, sh: 8'h00,
				ptr: mon_pkg::PTR_RST, cmd: 1'b0, dat: 1'b0, rw: 1'b0,
				ara: 1'b0, ack: 1'b0, oe: 1'b0, sdo: 1'b1,
				scl_d: 1'b1, sda_d: 1'b1, stuck: 20'h00000,
				status: mon_pkg::STAT_RST, we: 1'b0, re: 1'b0,
				wdata: 8'h00, stat_clr: 1'b0, alert_ack: 1'b0,
				s0: mon_pkg::STRAP_LOW, s1: mon_pkg::STRAP_LOW};
		end else begin
			r <= next_r;
		end
	end

	// Outputs come straight from state flops.
	assign serial_data_out = r.sdo;
	assign serial_data_out_oe = r.oe;
	assign alert_ack = r.alert_ack;
	assign aux_pin_three = dr.strobe_n;
	assign aux_pin_three_oe = dr.strobe_oe;
	assign reg_addr = r.ptr;
	assign reg_wdata = r.wdata;
	assign reg_we = r.we;
	assign reg_re = r.re;
	assign adc_status = r.status;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	chk_stop_ptr_zero: assert property (
		stop_det && !stuck_hit |=> r.ptr == mon_pkg::PTR_RST)
		else $error("pointer not cleared by stop");
	chk_ptr_wrap: assert property (
		ptr_inc && r.ptr == mon_pkg::PTR_LAST |=> r.ptr == 8'h00)
		else $error("pointer did not wrap");
	chk_ptr_step: assert property (
		ptr_inc && r.ptr != mon_pkg::PTR_LAST
		|=> r.ptr == $past(r.ptr) + 8'h01)
		else $error("pointer did not advance by one");
	chk_status_clear: assert property (
		r.stat_clr && adc_new_evt == 8'h00 |=> r.status == 8'h00)
		else $error("status not cleared on read");
	chk_status_set_wins: assert property (
		adc_new_evt != 8'h00
		|=> (r.status & $past(adc_new_evt)) == $past(adc_new_evt))
		else $error("status event lost");
	chk_own_addr_ack: assert property (
		addr_done && is_own |=> r.oe ##1 r.oe[*1])
		else $error("own address not acknowledged");
	chk_mass_addr_ack: assert property (
		addr_done && r.sh == {mon_pkg::MASS_ADDR, 1'b0} |=> r.oe)
		else $error("mass-write address not acknowledged");
	chk_ara_idle: assert property (
		addr_done && r.sh == {mon_pkg::ARA_ADDR, 1'b1} && !alert_pending
		&& !is_own |=> !r.oe && r.st == mon_pkg::ST_IDLE)
		else $error("alert address answered without alert");
	chk_foreign_addr: assert property (
		addr_done && !addr_ok |=> !r.oe)
		else $error("foreign address acknowledged");
	chk_stuck_release: assert property (
		stuck_hit |=> !r.oe && r.st == mon_pkg::ST_IDLE)
		else $error("stuck bus did not release data line");
	chk_write_pulse: assert property (
		r.we |=> !r.we ##1 !r.we)
		else $error("write strobe longer than one cycle");

	cov_write: cover property (r.we);
	cov_read: cover property (r.re);
	cov_alert_reply: cover property (r.alert_ack);
	cov_stuck: cover property (stuck_hit);
endmodule

// ==== tb/mon_bus_master.sv ====
// Behavioural bus master that drives the serial clock and data lines.
`timescale 1ns/1ps
module mon_bus_master (
	input  wire logic sys_clk, // Bench clock used for phase timing.
	input  wire logic sda,     // Resolved data line level.
	output logic      scl,     // Serial clock driven by the master.
	output logic      sda_oe   // High while the master pulls data low.
);
	////////////////////////////////////////////////////////////////////////
	// The clock starts driven high; data starts released so its pull-up holds it high.
	initial begin
		scl = 1'b1;
		sda_oe = 1'b0;
	end

	// One half period of the 400 ns serial clock.
	task automatic half();
		repeat (4) @(negedge sys_clk);
	endtask

	// Start or repeated start: data falls while the clock is high.
	task automatic start();
		sda_oe = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_oe = 1'b1;
		half();
		scl = 1'b0;
	endtask

	// One bit: data changes a cycle after the clock fall, sampled late high.
	task automatic bitx(input logic b, output logic r);
		@(negedge sys_clk);
		sda_oe = ~b;
		repeat (3) @(negedge sys_clk);
		scl = 1'b1;
		half();
		r = sda;
		scl = 1'b0;
	endtask

	// Stop: data rises while the clock stays high, then the bus is idle.
	task automatic stop();
		@(negedge sys_clk);
		sda_oe = 1'b1;
		repeat (3) @(negedge sys_clk);
		scl = 1'b1;
		half();
		sda_oe = 1'b0;
		half();
	endtask

	// Sends a byte MSB first and returns the ninth-clock level.
	task automatic wr(input logic [7:0] d, output logic ack_n);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, ack_n);
	endtask

	// Reads a byte, then acks it unless it is the last one.
	task automatic rd(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
		bitx(last, r);
	endtask
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the monitor serial slave port.
`timescale 1ns/1ps
module tb;
	localparam int STUCK = 600;   // Shortened limit, above any low-bit run.
	localparam int CEIL  = 60000; // Cycle ceiling for a hung run.

	logic       sys_clk;
	logic       nrst;
	logic       scl;
	logic       m_oe;
	wire        sda;
	logic       d_out;
	logic       d_oe;
	logic [1:0] strap0;
	logic [1:0] strap1;
	logic       shutdown;
	logic       alert_pending;
	logic       alert_ack;
	logic [7:0] evt;
	logic [1:0] dr_mode;
	logic       aux;
	logic       aux_oe;
	logic [7:0] reg_addr;
	logic [7:0] reg_wdata;
	logic       reg_we;
	logic       reg_re;
	logic [7:0] rdata;
	logic [7:0] adc_status;
	logic [7:0] mem [0:255];
	logic [7:0] ref_mem [0:255];
	logic [7:0] stat_exp;
	logic [7:0] d;
	logic [6:0] own;
	logic       an;
	logic       ack_seen;
	int         err_count;
	int         compares;
	int         cyc;
	int         n;
	int         re_cnt;
	integer     seed;

	////////////////////////////////////////////////////////////////////////
	// Open-drain data line with a pull-up, and the register file.
	assign sda = ~(m_oe | d_oe);
	assign rdata = mem[reg_addr];
	initial sys_clk = 1'b0;
	always #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (reg_we === 1'b1) mem[reg_addr] <= reg_wdata;
		if (alert_ack === 1'b1) ack_seen <= 1'b1;
		if (reg_re === 1'b1) re_cnt++;
		cyc = cyc + 1;
		if (cyc == CEIL) begin
			err_count++;
			results();
		end
	end

	mon_i2c_slave #(.STUCK_CYC(20'(STUCK))) DUT (
		.sys_clk(sys_clk), .nrst(nrst), .scl_in(scl),
		.serial_data_in(sda), .serial_data_out(d_out),
		.serial_data_out_oe(d_oe), .addr_strap_zero(strap0),
		.addr_strap_one(strap1), .shutdown(shutdown),
		.alert_pending(alert_pending), .alert_ack(alert_ack),
		.adc_new_evt(evt), .dr_mode(dr_mode), .aux_pin_three(aux),
		.aux_pin_three_oe(aux_oe), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
		.reg_rdata(rdata), .adc_status(adc_status));
	mon_bus_master bm (.sys_clk(sys_clk), .sda(sda), .scl(scl),
		.sda_oe(m_oe));

	////////////////////////////////////////////////////////////////////////
	// Comparison, timing and reporting helpers.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic cycles(input int k);
		repeat (k) @(negedge sys_clk);
	endtask
	task automatic results();
		$display("compares %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	function automatic logic [7:0] nxt(input logic [7:0] p);
		return (p == 8'h97) ? 8'h00 : p + 8'h01;
	endfunction
	function automatic logic [6:0] own_of(input logic [1:0] a, b);
		return {3'h6, 4'(4'(a) * 4'h3 + 4'(b))};
	endfunction
	function automatic logic [7:0] exp_rd(input logic [7:0] p);
		if (p == mon_pkg::ID_HI_ADDR) return mon_pkg::ID_HI_VAL;
		if (p == mon_pkg::ID_LO_ADDR) return mon_pkg::ID_LO_VAL;
		if (p == mon_pkg::STAT_ADDR) return stat_exp;
		return ref_mem[p];
	endfunction

	// Address-only transaction that checks the acknowledge level.
	task automatic probe(input logic [7:0] a, input logic exp_n);
		bm.start();
		bm.wr(a, an);
		chk(an, exp_n);
		bm.stop();
	endtask

	// Writes n random bytes from cmd and checks the stored values.
	task automatic wr_regs(input logic [7:0] cmd, input int k);
		logic [7:0] p;
		p = cmd;
		bm.start();
		bm.wr({own, 1'b0}, an);
		chk(an, 1'b0);
		bm.wr(cmd, an);
		chk(an, 1'b0);
		repeat (k) begin
			ref_mem[p] = 8'($random(seed));
			bm.wr(ref_mem[p], an);
			chk(an, 1'b0);
			p = nxt(p);
		end
		bm.stop();
		chk(reg_addr, 8'h00);
		p = cmd;
		repeat (k) begin
			chk(mem[p], ref_mem[p]);
			p = nxt(p);
		end
	endtask

	// Command write, repeated start, then n bytes read back.
	task automatic rd_regs(input logic [7:0] cmd, input int k);
		logic [7:0] p;
		p = cmd;
		bm.start();
		re_cnt = 0;
		bm.wr({own, 1'b0}, an);
		bm.wr(cmd, an);
		chk(an, 1'b0);
		bm.start();
		bm.wr({own, 1'b1}, an);
		chk(an, 1'b0);
		for (int i = 1; i <= k; i++) begin
			bm.rd(i == k, d);
			chk(d, exp_rd(p));
			p = nxt(p);
		end
		bm.stop();
		chk(16'(re_cnt), 16'(k));
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence of scenarios.
	initial begin
		seed = 96;
		nrst = 1'b0;
		strap0 = mon_pkg::STRAP_OPEN;
		strap1 = mon_pkg::STRAP_LOW;
		{shutdown, alert_pending, ack_seen} = 3'h0;
		evt = 8'h00;
		dr_mode = 2'h0;
		stat_exp = 8'h00;
		{err_count, compares, cyc, re_cnt} = 0;
		cycles(6);
		nrst = 1'b1;
		cycles(5);
		own = own_of(strap0, strap1);
		chk(d_oe, 1'b0);
		chk(aux, 1'b1);
		chk(reg_addr, 8'h00);
		chk(aux_oe, 1'b0);
		chk(d_out, 1'b1);
		chk(adc_status, mon_pkg::STAT_RST);
		$display("test reset finished");
		// Byte, word and extended writes, the last across the wrap.
		for (int i = 0; i < 3; i++) wr_regs(8'h10 << i, i + 1);
		wr_regs(8'h97, 3);
		rd_regs(8'h97, 3);
		for (int i = 0; i < 3; i++) rd_regs(8'h10 << i, i + 1);
		rd_regs(mon_pkg::ID_HI_ADDR, 1);
		rd_regs(mon_pkg::ID_LO_ADDR, 1);
		$display("test write_read finished");
		// Latched strobe, status flags and clear on read.
		dr_mode = 2'h2;
		stat_exp = 8'($random(seed)) | 8'h01;
		evt = stat_exp;
		cycles(1);
		evt = 8'h00;
		cycles(4);
		chk(adc_status, stat_exp);
		cycles(50);
		chk(aux, 1'b0);
		chk(aux_oe, 1'b1);
		rd_regs(mon_pkg::STAT_ADDR, 1);
		cycles(3);
		chk(adc_status, 8'h00);
		chk(aux, 1'b1);
		stat_exp = 8'h00;
		// Off modes ignore events; pulse mode gives one timed low pulse.
		for (int m = 0; m < 4; m += 3) begin
			dr_mode = 2'(m);
			evt = 8'h02;
			cycles(1);
			evt = 8'h00;
			cycles(30);
			chk(aux, 1'b1);
		end
		dr_mode = 2'h1;
		evt = 8'h04;
		cycles(1);
		evt = 8'h00;
		n = 0;
		for (int w = 0; w < 10 && aux !== 1'b0; w++) cycles(1);
		while (aux === 1'b0 && n < 400) begin
			n++;
			cycles(1);
		end
		chk(16'(n), 16'(mon_pkg::PULSE_CYC));
		$display("test strobe finished");
		// Every strap combination, neighbours, prefix and mass write.
		for (int a = 0; a < 3; a++) begin
			for (int b = 0; b < 3; b++) begin
				strap0 = 2'(a);
				strap1 = 2'(b);
				cycles(5);
				own = own_of(strap0, strap1);
				probe({own, 1'b0}, 1'b0);
				probe({3'h6, own[3:0] ^ 4'h8, 1'b0}, 1'b1);
				probe({3'h2, own[3:0], 1'b0}, 1'b1);
				probe({mon_pkg::MASS_ADDR, 1'b0}, 1'b0);
				if (own != mon_pkg::MASS_ADDR)
					probe({mon_pkg::MASS_ADDR, 1'b1}, 1'b1);
			end
		end
		// Straps frozen while in shutdown.
		shutdown = 1'b1;
		strap0 = mon_pkg::STRAP_LOW;
		strap1 = mon_pkg::STRAP_LOW;
		cycles(5);
		probe({own, 1'b0}, 1'b0);
		probe({7'h60, 1'b0}, 1'b1);
		shutdown = 1'b0;
		cycles(5);
		own = own_of(strap0, strap1);
		$display("test address finished");
		// Alert response only while an alert is pending.
		probe({mon_pkg::ARA_ADDR, 1'b1}, 1'b1);
		alert_pending = 1'b1;
		bm.start();
		bm.wr({mon_pkg::ARA_ADDR, 1'b1}, an);
		chk(an, 1'b0);
		bm.rd(1'b1, d);
		chk(d, {own, 1'b1});
		bm.stop();
		chk(ack_seen, 1'b1);
		alert_pending = 1'b0;
		// Clock held low during the ack: the pull-down must let go.
		bm.start();
		for (int i = 7; i >= 0; i--) bm.bitx(i == 0 ? 1'b0 : own[i - 1], an);
		cycles(10);
		chk(d_oe, 1'b1);
		chk(d_out, 1'b0);
		cycles(STUCK + 60);
		chk(d_oe, 1'b0);
		bm.stop();
		probe({own, 1'b0}, 1'b0);
		$display("test alert_stuck finished");
		results();
	end
endmodule
